//--- sim/ldr_assertions.sv
/*
 * port checker for ldr_top: register, transmit pointer and dma write relations.
 * assumes it is bound into ldr_top with clkEn held high and one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module ldr_assertions
  import ldr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // receive path and dma
  input wire logic byteValid,
  input wire logic frameEnd,
  input wire ldr_frame_end_type frameInfo,
  input wire ldr_mem_write_type memWrite,
  input wire logic [15:0] txStartAddr,
  input wire logic [15:0] txLength,
  input wire logic rxAbort
);
  // ***********************************************************
  // port relations
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // transmit page lands in the high byte, low byte forced to zero
  a_tx_page_load: assert property (regWrite && regAddr == ADDR_TX_PAGE |=>
    txStartAddr == {$past(regWrData), LOW_BYTE_ZERO}) else $error("tx start address wrong");
  a_len_low_byte: assert property (regWrite && regAddr == ADDR_TX_LEN_LO |=>
    txLength[7:0] == $past(regWrData)) else $error("tx length low byte wrong");
  a_len_high_byte: assert property (regWrite && regAddr == ADDR_TX_LEN_HI |=>
    txLength[15:8] == $past(regWrData)) else $error("tx length high byte wrong");
  // read data only stands in the cycle after a read strobe
  a_read_idle_zero: assert property (!regRead |=> regRdData == 8'h00) else $error("read data not idle");
  // every memory write comes from a byte or from a frame end two cycles back
  a_write_has_cause: assert property (memWrite.valid |->
    $past(byteValid) || $past(frameEnd, 2)) else $error("memory write without cause");
  a_status_at_head: assert property (memWrite.valid && $past(frameEnd, 2) |->
    memWrite.addr[7:0] == STATUS_OFFSET && memWrite.data[0] == !(|memWrite.data[4:1]))
    else $error("status byte misplaced or intact bit wrong");
  a_overflow_no_status: assert property (frameEnd && frameInfo.overflow |-> ##2 !memWrite.valid)
    else $error("status written for overflowed frame");
  a_align_needs_crc: assert property (memWrite.valid && $past(frameEnd, 2) |->
    !(memWrite.data[2] && !memWrite.data[1])) else $error("alignment flag without crc flag");
  a_abort_one_pulse: assert property (rxAbort |=> !rxAbort) else $error("abort longer than one cycle");
endmodule // ldr_assertions
bind ldr_top ldr_assertions ldr_assertions_inst (.clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData, .byteValid, .frameEnd, .frameInfo, .memWrite, .txStartAddr, .txLength, .rxAbort);
`default_nettype wire

//--- sim/ldr_buffer_mem.sv
/*
 * buffer memory model: stores every local dma byte write and counts them.
 * assumes writes arrive as one-cycle valid pulses synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module ldr_buffer_mem
  import ldr_pkg::*;
(
  // clock
  input wire logic clk,
  // dma write port
  input wire ldr_mem_write_type memWrite
);
  // ***********************************************************
  // storage
  // ***********************************************************
  logic [7:0] mem [0:65535];
  int writes = 0;
  // memory never stalls, so each valid cycle stores one byte
  always @(posedge clk) begin
    if (memWrite.valid === 1'b1) begin
      mem[memWrite.addr] <= memWrite.data;
      writes <= writes + 1;
    end
  end
endmodule // ldr_buffer_mem
`default_nettype wire

//--- sim/ldr_top_test.sv
/*
 * self-checking bench for ldr_top against a behavioural ring and status model.
 * assumes the buffer memory model and the bound checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module ldr_top_test
  import ldr_pkg::*;
;
  // ***********************************************************
  // stimulus and model state
  // ***********************************************************
  logic clk = 0, resetn = 0, regWrite = 0, regRead = 0, frameStart = 0, frameForUs = 0;
  logic byteValid = 0, frameEnd = 0, carrierPin = 0, jabberPin = 0, rxAbort, listen = 0, sawAbort = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, byteData = 8'h00, regRdData, rd, cur = 8'h46, stop = 8'h80;
  logic [15:0] txStartAddr, txLength;
  logic [31:0] seed = 32'h47af5428;
  ldr_frame_end_type frameInfo = '0;
  ldr_mem_write_type memWrite;
  int err_total = 0, check_count = 0, tCrc = 0, tAli = 0, tLost = 0;
  logic [3:0] ra [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hf};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h46, 8'h80, 8'h46, 8'h46, 8'h04, 8'h46, 8'h00, 8'h00, 8'h00};
  ldr_top ldr_top_inst (.clk, .resetn, .clkEn(1'b1), .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .frameStart, .frameForUs, .byteValid, .byteData, .frameEnd, .frameInfo, .carrierPin, .jabberPin,
    .memWrite, .txStartAddr, .txLength, .rxAbort);
  ldr_buffer_mem ldr_buffer_mem_inst (.clk, .memWrite);
  initial forever #5 clk = ~clk;
  // abort is a one-cycle pulse, so latch it for the frame check
  always @(posedge clk) if (rxAbort === 1'b1) sawAbort <= 1'b1;
  // ***********************************************************
  // tasks
  // ***********************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    // read data stands for one cycle only: take it once it has settled
    @(negedge clk);
    rd = regRdData;
    @(posedge clk);
  endtask
  // long frames (n of 250 or more) are meant to hit the boundary page
  task automatic frame(input int n, input ldr_frame_end_type fi, input logic keep, input logic us,
    input logic [7:0] mask);
    logic [31:0] r;
    logic [7:0] first, st;
    logic ok, lost;
    int w0;
    w0 = ldr_buffer_mem_inst.writes;
    sawAbort = 1'b0;
    ok = us && !listen && !fi.overflow && (!fi.crcBad || keep) && n < 250;
    // a listen-only frame or a ring overrun leaves the frame missed
    lost = us && (listen || n >= 250);
    st = {1'b0, listen, fi.multicast, lost, fi.overflow, fi.crcBad & fi.offByte, fi.crcBad,
      us && !(fi.crcBad | fi.overflow | lost)};
    @(posedge clk);
    frameStart <= 1'b1;
    frameForUs <= us;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      if (i == 0) first = r[7:0];
      @(posedge clk);
      frameStart <= 1'b0;
      byteValid <= 1'b1;
      byteData <= r[7:0];
    end
    @(posedge clk);
    byteValid <= 1'b0;
    byteData <= ~byteData;
    frameEnd <= 1'b1;
    frameInfo <= fi;
    @(posedge clk);
    frameEnd <= 1'b0;
    repeat (4) @(posedge clk);
    tCrc += us && fi.crcBad;
    tAli += us && fi.crcBad && fi.offByte;
    tLost += lost;
    rdr(ADDR_RX_STATUS);
    chk("status", rd & mask, st & mask);
    // data bytes land before the end report decides; only the status byte depends on it
    if (n < 250) chk("writes", ldr_buffer_mem_inst.writes, w0 + ((us && !listen) ? n : 0) + (ok ? 1 : 0));
    else chk("abort", sawAbort, 1'b1);
    if (ok) begin
      chk("status byte", ldr_buffer_mem_inst.mem[{cur, STATUS_OFFSET}], st);
      chk("first byte", ldr_buffer_mem_inst.mem[{cur, FIRST_DATA_OFFSET}], first);
      cur = (cur + 8'h01 == stop) ? 8'h46 : cur + 8'h01;
    end
    rdr(ADDR_CUR_PAGE);
    chk("current page", rd, cur);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ***********************************************************
  // main sequence and watchdog
  // ***********************************************************
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  initial begin
    logic [31:0] r;
    ldr_frame_end_type fi;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      rdr(ra[i]);
      chk("reset value", rd, rv[i]);
    end
    wr(ADDR_CUR_PAGE, RING_START_RESET);
    wr(ADDR_LOCAL_LO, 8'hff);
    rdr(ADDR_LOCAL_LO);
    chk("read-only low address", rd, 8'h04);
    r = rnd();
    wr(ADDR_TX_PAGE, r[7:0]);
    wr(ADDR_TX_LEN_LO, r[15:8]);
    wr(ADDR_TX_LEN_HI, r[23:16]);
    @(negedge clk);
    chk("tx start", txStartAddr, {r[7:0], 8'h00});
    chk("tx length", txLength, r[23:8]);
    rdr(ADDR_TX_LEN_HI);
    chk("tx length high", rd, r[23:16]);
    stop = 8'h4a;
    wr(ADDR_RING_STOP, stop);
    wr(ADDR_RING_BOUND, 8'h20);
    // random frames run several times round the short ring
    for (int k = 0; k < 14; k++) begin
      r = rnd();
      fi = {r[0], r[3], r[1] & r[2] & !r[0], r[4]};
      wr(ADDR_RX_CONFIG, {7'h00, r[5]});
      frame(1 + r[11:8], fi, r[5], 1'b1, 8'hff);
    end
    frame(3, '0, 1'b0, 1'b0, 8'hff);
    wr(ADDR_RX_CONFIG, 8'h20);
    listen = 1'b1;
    frame(4, '0, 1'b0, 1'b1, 8'h50);
    wr(ADDR_RX_CONFIG, 8'h00);
    listen = 1'b0;
    rdr(ADDR_RX_STATUS);
    chk("receiver off cleared", rd[6], 1'b0);
    carrierPin <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(ADDR_RX_STATUS);
    chk("deferring on carrier", rd[7], 1'b1);
    carrierPin <= 1'b0;
    jabberPin <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(ADDR_RX_STATUS);
    chk("deferring on jabber", rd[7], 1'b1);
    jabberPin <= 1'b0;
    repeat (4) @(posedge clk);
    rdr(ADDR_RX_STATUS);
    chk("deferring released", rd[7], 1'b0);
    wr(ADDR_RING_BOUND, (cur + 8'h01 == stop) ? 8'h46 : cur + 8'h01);
    frame(260, '0, 1'b0, 1'b1, 8'hff);
    wr(ADDR_RING_BOUND, 8'h20);
    frame(5, '0, 1'b0, 1'b1, 8'hff);
    rdr(ADDR_TALLY_CRC);
    chk("crc tally", rd, tCrc[7:0]);
    rdr(ADDR_TALLY_ALIGN);
    chk("alignment tally", rd, tAli[7:0]);
    rdr(ADDR_TALLY_LOST);
    chk("lost tally", rd, tLost[7:0]);
    rdr(ADDR_TALLY_CRC);
    chk("crc tally cleared", rd, 8'h00);
    end_sim();
  end
endmodule // ldr_top_test
`default_nettype wire

//--- verilog/ldr_pkg.sv
/*
 * constants, types and register map of the local dma receive ring and
 * receive status block.
 * assumes one system clock, an 8-bit register port and a byte-wide buffer
 * memory write port that never stalls.
 */
// Behaviour
// - good packet: status byte written into buffer memory with the packet.
// - errored packet kept when saving enabled: status written at packet head.
// - errored packet rejected: status byte never written to memory.
// - status cleared when next packet starts; undefined before first reception.
// - bit 0 set only when crc, alignment, overflow and missed bits are zero.
// - bit 1 on crc error, bumps checksum tally; also set on alignment error. code sets bit 1 but skips the tally for listen-only frames.
// - bit 2 when packet ends off byte boundary with bad crc; bumps alignment tally. code sets bit 2 but skips the tally for listen-only frames.
// - fifo overflow sets bit 3 and aborts the packet.
// - bit 4 and lost tally when no buffers or listen-only mode.
// - bit 5 clear for physical match, set for multicast match.
// - bit 6 set entering listen-only, cleared on leaving it.
// - bit 7 on carrier or collision; held while jabber collision persists.
// - alignment-without-crc never reported; both bits mean both errors.
// - every register is 8 bits; transmit length split low and high.
// - transmit address is page in bits 15..8 with low byte zero.
// - transmit length up to 64 Kbytes, never truncated above 1500 bytes.
// - receive ring of 256-byte pages bounded by start and stop pages.
// - next page equal to boundary aborts the local dma.
// - current page holds packet first buffer; pointers restored on error.
// - full local dma address readable as high and low bytes.
// - keep-errored bit decides whether errored packets and status are stored.
// - listen-only checks packets, stores nothing, counts them as lost.
`default_nettype none
package ldr_pkg;
  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [3:0] ADDR_RX_STATUS = 4'hc;
  localparam logic [3:0] ADDR_TX_PAGE = 4'h0;
  localparam logic [3:0] ADDR_TX_LEN_LO = 4'h1;
  localparam logic [3:0] ADDR_TX_LEN_HI = 4'h2;
  localparam logic [3:0] ADDR_RING_START = 4'h3;
  localparam logic [3:0] ADDR_RING_STOP = 4'h4;
  localparam logic [3:0] ADDR_RING_BOUND = 4'h5;
  localparam logic [3:0] ADDR_CUR_PAGE = 4'h6;
  localparam logic [3:0] ADDR_LOCAL_LO = 4'h7;
  localparam logic [3:0] ADDR_LOCAL_HI = 4'h8;
  localparam logic [3:0] ADDR_RX_CONFIG = 4'h9;
  localparam logic [3:0] ADDR_TALLY_ALIGN = 4'ha;
  localparam logic [3:0] ADDR_TALLY_CRC = 4'hb;
  localparam logic [3:0] ADDR_TALLY_LOST = 4'hd;
  // ***********************************************************
  // field positions and values
  // ***********************************************************
  localparam int CFG_KEEP_ERR = 0;
  localparam int CFG_LISTEN = 5;
  localparam logic [7:0] TALLY_MAX = 8'hc0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RING_START_RESET = 8'h46;
  localparam logic [7:0] RING_STOP_RESET = 8'h80;
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] FIRST_DATA_OFFSET = 8'h04;

  // receive status byte, bit 7 first
  typedef struct packed {
    logic deferringFlag;
    logic receiverOffFlag;
    logic groupAddressFlag;
    logic missedFrameFlag;
    logic fifoOverflowFlag;
    logic alignmentErrorFlag;
    logic crcErrorFlag;
    logic receivedIntact;
  } ldr_status_type;

  // end-of-frame report from the network receive path
  typedef struct packed {
    logic crcBad;
    logic offByte;
    logic overflow;
    logic multicast;
  } ldr_frame_end_type;

  // memory write from the local dma
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } ldr_mem_write_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_STATUS = 2'b11,
    ST_DROP = 2'b10
  } ldr_state_type;
endpackage
`default_nettype wire

//--- verilog/ldr_top.sv
/*
 * local dma receive ring, transmit pointer registers and receive status.
 * assumes rx path pulses are synchronous to clk and at most one per cycle;
 * carrier and jabber levels come from pins and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module ldr_top
  import ldr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // network receive path
  input wire logic frameStart,
  input wire logic frameForUs,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic frameEnd,
  input wire ldr_frame_end_type frameInfo,
  // asynchronous line levels
  input wire logic carrierPin,
  input wire logic jabberPin,
  // buffer memory and transmit dma
  output ldr_mem_write_type memWrite,
  output logic [15:0] txStartAddr,
  output logic [15:0] txLength,
  output logic rxAbort
);
  // ***********************************************************
  // reset and input synchronisers
  // ***********************************************************
  logic [1:0] rstSync;
  logic rstn;
  logic [1:0] carSync;
  logic [1:0] jabSync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // carrier and jabber come off the line: two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carSync <= 2'b00;
      jabSync <= 2'b00;
    end else if (clkEn) begin
      carSync <= {carSync[0], carrierPin};
      jabSync <= {jabSync[0], jabberPin};
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [7:0] txPage;
  logic [7:0] txLenLo;
  logic [7:0] txLenHi;
  logic [7:0] ringStart;
  logic [7:0] ringStop;
  logic [7:0] ringBound;
  logic [7:0] curPage;
  logic [7:0] rxConfig;
  logic [7:0] tallyAlign;
  logic [7:0] tallyCrc;
  logic [7:0] tallyLost;
  ldr_status_type status;
  ldr_state_type state;
  logic [15:0] localAddr;
  logic [7:0] nextPage;
  logic [7:0] wrapPage;
  logic keepErr;
  logic listen;
  logic errFrame;
  logic frameEndOk;
  logic goodFrame;

  assign keepErr = rxConfig[CFG_KEEP_ERR];
  assign listen = rxConfig[CFG_LISTEN];

  // software writes; current page is written at init only by convention
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txPage <= RESET_BYTE;
      txLenLo <= RESET_BYTE;
      txLenHi <= RESET_BYTE;
      ringStart <= RING_START_RESET;
      ringStop <= RING_STOP_RESET;
      ringBound <= RING_START_RESET;
      rxConfig <= RESET_BYTE;
    end else if (clkEn && regWrite) begin
      case (regAddr)
        ADDR_TX_PAGE: txPage <= regWrData;
        ADDR_TX_LEN_LO: txLenLo <= regWrData;
        ADDR_TX_LEN_HI: txLenHi <= regWrData;
        ADDR_RING_START: ringStart <= regWrData;
        ADDR_RING_STOP: ringStop <= regWrData;
        ADDR_RING_BOUND: ringBound <= regWrData;
        ADDR_RX_CONFIG: rxConfig <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // transmit pointer: page in the high byte, low byte zero
  assign txStartAddr = {txPage, LOW_BYTE_ZERO};
  // full 16 bits, no cap so long frames pass untruncated
  assign txLength = {txLenHi, txLenLo};

  // ***********************************************************
  // ring pointer arithmetic
  // ***********************************************************
  // wrap before comparing with the boundary so a full ring is seen
  always_comb begin
    wrapPage = localAddr[15:8] + 8'h01;
    if (wrapPage == ringStop) begin
      wrapPage = ringStart;
    end
  end
  assign nextPage = wrapPage;

  assign errFrame = frameInfo.crcBad;
  assign frameEndOk = !frameInfo.overflow && !errFrame;
  assign goodFrame = frameEndOk;

  // ***********************************************************
  // receive dma state machine
  // ***********************************************************
  logic pageCross;
  logic bndHit;
  assign pageCross = (localAddr[7:0] == 8'hff);
  assign bndHit = pageCross && (nextPage == ringBound);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      localAddr <= {RING_START_RESET, FIRST_DATA_OFFSET};
      curPage <= RING_START_RESET;
      memWrite <= '0;
      rxAbort <= 1'b0;
    end else if (clkEn) begin
      memWrite.valid <= 1'b0;
      rxAbort <= 1'b0;
      if (regWrite && regAddr == ADDR_CUR_PAGE) begin
        curPage <= regWrData;
        localAddr <= {regWrData, FIRST_DATA_OFFSET};
      end
      case (state)
        ST_IDLE: begin
          if (frameStart) begin
            localAddr <= {curPage, FIRST_DATA_OFFSET};
            if (listen || !frameForUs) begin
              state <= ST_DROP;
            end else begin
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (frameEnd) begin
            if (frameInfo.overflow || (errFrame && !keepErr)) begin
              localAddr <= {curPage, FIRST_DATA_OFFSET};
              state <= ST_IDLE;
            end else begin
              state <= ST_STATUS;
            end
          end else if (byteValid) begin
            memWrite.valid <= 1'b1;
            memWrite.addr <= localAddr;
            memWrite.data <= byteData;
            if (bndHit) begin
              rxAbort <= 1'b1;
              localAddr <= {curPage, FIRST_DATA_OFFSET};
              state <= ST_DROP;
            end else if (pageCross) begin
              localAddr <= {nextPage, LOW_BYTE_ZERO};
            end else begin
              localAddr <= localAddr + 16'h0001;
            end
          end
        end
        ST_STATUS: begin
          // status at the head of the packet's first page
          memWrite.valid <= 1'b1;
          memWrite.addr <= {curPage, STATUS_OFFSET};
          memWrite.data <= status;
          curPage <= nextPage;
          localAddr <= {nextPage, FIRST_DATA_OFFSET};
          state <= ST_IDLE;
        end
        ST_DROP: begin
          if (frameEnd) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // receive status
  // ***********************************************************
  logic lostFrame;
  assign lostFrame = frameStart && frameForUs && (listen || state != ST_IDLE);

  // frame bits rebuilt at each end; the line bits track their causes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else if (clkEn) begin
      status.receiverOffFlag <= listen;
      status.deferringFlag <= carSync[1] || jabSync[1];
      if (frameStart) begin
        status.receivedIntact <= 1'b0;
        status.crcErrorFlag <= 1'b0;
        status.alignmentErrorFlag <= 1'b0;
        status.fifoOverflowFlag <= 1'b0;
        status.missedFrameFlag <= lostFrame;
        status.groupAddressFlag <= 1'b0;
      end else if (frameEnd && state != ST_IDLE) begin
        status.crcErrorFlag <= frameInfo.crcBad;
        // alignment only reported together with a crc failure
        status.alignmentErrorFlag <= frameInfo.crcBad && frameInfo.offByte;
        status.fifoOverflowFlag <= frameInfo.overflow;
        status.groupAddressFlag <= frameInfo.multicast;
        status.receivedIntact <= goodFrame && !status.missedFrameFlag && state == ST_DATA;
      end
      // a ring overrun abort means the frame found no buffer, so it counts as missed
      if (rxAbort) begin
        status.missedFrameFlag <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // tallies, saturating, cleared on read; a bump beats the clear
  // ***********************************************************
  logic bumpCrc;
  logic bumpAlign;
  logic bumpLost;
  assign bumpCrc = clkEn && frameEnd && state != ST_IDLE && state != ST_DROP && frameInfo.crcBad;
  assign bumpAlign = bumpCrc && frameInfo.offByte;
  assign bumpLost = clkEn && (lostFrame || (rxAbort && state == ST_DROP));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tallyCrc <= RESET_BYTE;
      tallyAlign <= RESET_BYTE;
      tallyLost <= RESET_BYTE;
    end else if (clkEn) begin
      if (bumpCrc) begin
        tallyCrc <= (tallyCrc == TALLY_MAX) ? tallyCrc : tallyCrc + 8'h01;
      end else if (regRead && regAddr == ADDR_TALLY_CRC) begin
        tallyCrc <= RESET_BYTE;
      end
      if (bumpAlign) begin
        tallyAlign <= (tallyAlign == TALLY_MAX) ? tallyAlign : tallyAlign + 8'h01;
      end else if (regRead && regAddr == ADDR_TALLY_ALIGN) begin
        tallyAlign <= RESET_BYTE;
      end
      if (bumpLost) begin
        tallyLost <= (tallyLost == TALLY_MAX) ? tallyLost : tallyLost + 8'h01;
      end else if (regRead && regAddr == ADDR_TALLY_LOST) begin
        tallyLost <= RESET_BYTE;
      end
    end
  end

  // ***********************************************************
  // read port: data one cycle after the strobe
  // ***********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= RESET_BYTE;
    end else if (clkEn) begin
      if (regRead) begin
        case (regAddr)
          ADDR_RX_STATUS: regRdData <= status;
          ADDR_TX_PAGE: regRdData <= txPage;
          ADDR_TX_LEN_LO: regRdData <= txLenLo;
          ADDR_TX_LEN_HI: regRdData <= txLenHi;
          ADDR_RING_START: regRdData <= ringStart;
          ADDR_RING_STOP: regRdData <= ringStop;
          ADDR_RING_BOUND: regRdData <= ringBound;
          ADDR_CUR_PAGE: regRdData <= curPage;
          ADDR_LOCAL_LO: regRdData <= localAddr[7:0];
          ADDR_LOCAL_HI: regRdData <= localAddr[15:8];
          ADDR_RX_CONFIG: regRdData <= rxConfig;
          ADDR_TALLY_ALIGN: regRdData <= tallyAlign;
          ADDR_TALLY_CRC: regRdData <= tallyCrc;
          ADDR_TALLY_LOST: regRdData <= tallyLost;
          default: regRdData <= RESET_BYTE;
        endcase
      end else begin
        regRdData <= RESET_BYTE;
      end
    end
  end
endmodule // ldr_top
`default_nettype wire
